// ==== inc/asc_pkg.sv ====
// Constants for the asynchronous static memory host port.
// Assumes a single core clock whose rate is given by CLK_MHZ.
`default_nettype none
package asc_pkg;
  localparam int CLK_MHZ          = 100;
  localparam int MEM_WORDS        = 524288;
  localparam int ADDR_BITS        = 19;
  localparam int DATA_BITS        = 8;

  // Device timing figures in ns
  localparam int READ_CYCLE_MIN_NS      = 55;
  localparam int ADDR_ACCESS_NS         = 55;
  localparam int SELECT_ACCESS_NS       = 55;
  localparam int OUT_ENABLE_ACCESS_NS   = 30;
  localparam int OUT_DISABLE_HIGHZ_NS   = 20;
  localparam int WRITE_CYCLE_MIN_NS     = 55;
  localparam int WRITE_PULSE_MIN_NS     = 45;
  localparam int SELECT_TO_END_MIN_NS   = 50;
  localparam int ADDR_TO_END_MIN_NS     = 50;
  localparam int DATA_SETUP_MIN_NS      = 25;
  localparam int WRITE_TO_OUTPUT_OFF_NS = 20;

  function automatic int ns_to_cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Least times round up to whole cycles
  localparam int READ_ACCESS_CYC = ns_to_cyc_up(
    max2(max2(ADDR_ACCESS_NS, SELECT_ACCESS_NS), OUT_ENABLE_ACCESS_NS));
  localparam int WRITE_PULSE_CYC = ns_to_cyc_up(
    max2(max2(WRITE_PULSE_MIN_NS, SELECT_TO_END_MIN_NS),
         max2(ADDR_TO_END_MIN_NS, DATA_SETUP_MIN_NS)));
  localparam int TURN_CYC        = ns_to_cyc_up(OUT_DISABLE_HIGHZ_NS);
  localparam int READ_CYCLE_CYC  = ns_to_cyc_up(READ_CYCLE_MIN_NS);
  localparam int WRITE_CYCLE_CYC = ns_to_cyc_up(WRITE_CYCLE_MIN_NS);

  localparam int TMR_BITS = 8;
  localparam logic [TMR_BITS-1:0] TMR_READ    = TMR_BITS'(READ_ACCESS_CYC - 1);
  localparam logic [TMR_BITS-1:0] TMR_WRITE   = TMR_BITS'(WRITE_PULSE_CYC - 1);
  localparam logic [TMR_BITS-1:0] TMR_TURN    = TMR_BITS'(TURN_CYC - 1);
  localparam logic [TMR_BITS-1:0] TMR_RECOVER = TMR_BITS'(READ_CYCLE_CYC - 1);

  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_ADDR, ST_RD_ACCESS, ST_RD_END,
    ST_WR_ADDR, ST_WR_PULSE, ST_WR_END, ST_RETAIN, ST_RECOVER
  } asc_state_type;
endpackage
`default_nettype wire

// ==== rtl/asc_dq_pad.sv ====
// Registered driver and capture stage for the shared data lines.
// Assumes the pin resolver outside combines dq_o with dq_oe_n_o.
`default_nettype none
`timescale 1ns/100ps
module asc_dq_pad #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             drive_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             capture_i,
  input  wire logic [WIDTH-1:0] dq_i,
  output logic      [WIDTH-1:0] dq_o,
  output logic                  dq_oe_n_o,
  output logic      [WIDTH-1:0] rdata_o
);
  typedef struct packed {
    logic [WIDTH-1:0] dq;
    logic             oe_n;
    logic [WIDTH-1:0] rdata;
  } asc_pad_type;

  asc_pad_type r;
  asc_pad_type next_r;

  always_comb begin
    next_r      = r;
    next_r.oe_n = ~drive_i;
    // Hold the last written value while released to avoid needless toggling
    if (drive_i) begin
      next_r.dq = wdata_i;
    end
    if (capture_i) begin
      next_r.rdata = dq_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= '{dq: '0, oe_n: 1'b1, rdata: '0};
    end else begin
      r <= next_r;
    end
  end

  assign dq_o      = r.dq;
  assign dq_oe_n_o = r.oe_n;
  assign rdata_o   = r.rdata;
endmodule
`default_nettype wire

// ==== rtl/asc_sram_host.sv ====
// Host controller for an asynchronous 512K by 8 static memory.
// Assumes pin inputs are synchronous to core_clk_i and that the
// board wiring resolves the data lines from dq and its enable.
//
// Functional notes
// - Select and write strobe stay high whenever the address changes.
// - With output enable low, strobe low time exceeds turn-off plus setup.
// - Never drive write data while the memory drives the bus.
// - Address is valid no later than select falls for reads.
// - Each read cycle lasts at least 55 ns before the next address.
// - Each write cycle lasts at least 55 ns address to address.
// - Strobe low 45 ns; address and select held 50 ns before write end.
// - Zero address setup before strobe and zero recovery after write end.
// - Write data valid 25 ns before write end, held 0 ns after.
// - Select high by retention entry; wait one read cycle before resuming.
`default_nettype none
`timescale 1ns/100ps
module asc_sram_host
  import asc_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_BITS,
  parameter int DATA_WIDTH = DATA_BITS
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  // User request side
  input  wire logic                  req_valid_i,
  input  wire logic                  req_write_i,
  input  wire logic [ADDR_WIDTH-1:0] req_addr_i,
  input  wire logic [DATA_WIDTH-1:0] req_wdata_i,
  output logic                       req_ready_o,
  output logic                       rsp_valid_o,
  output logic      [DATA_WIDTH-1:0] rsp_rdata_o,
  output logic                       wr_done_o,
  // Data retention handshake
  input  wire logic                  retain_req_i,
  output logic                       retain_ack_o,
  // Memory pins
  output logic      [ADDR_WIDTH-1:0] word_address_o,
  output logic                       chip_select_n_o,
  output logic                       write_strobe_n_o,
  output logic                       output_enable_n_o,
  output logic      [DATA_WIDTH-1:0] data_lines_o,
  output logic                       data_lines_oe_n_o,
  input  wire logic [DATA_WIDTH-1:0] data_lines_i
);
  if (ADDR_WIDTH < 1 || (1 << ADDR_WIDTH) > MEM_WORDS) begin : g_chk_addr
    $error("asc_sram_host ADDR_WIDTH exceeds the memory depth");
  end
  if (DATA_WIDTH != DATA_BITS) begin : g_chk_data
    $error("asc_sram_host DATA_WIDTH must match the memory word");
  end
  if (READ_ACCESS_CYC + 2 < READ_CYCLE_CYC) begin : g_chk_rc
    $error("asc_sram_host read timing cannot meet the read cycle");
  end
  if (WRITE_PULSE_CYC + 1 < WRITE_CYCLE_CYC) begin : g_chk_wc
    $error("asc_sram_host write timing cannot meet the write cycle");
  end
  if (WRITE_PULSE_CYC * 1000 <=
      (WRITE_TO_OUTPUT_OFF_NS + DATA_SETUP_MIN_NS) * CLK_MHZ) begin : g_chk_wp
    $error("asc_sram_host write pulse too short for enable-low writes");
  end

  typedef struct packed {
    asc_state_type         state;
    logic [ADDR_WIDTH-1:0] addr;
    logic                  cs_n;
    logic                  we_n;
    logic                  oe_n;
    logic                  drive;
    logic [DATA_WIDTH-1:0] wdata;
    logic                  ready;
    logic                  rsp_valid;
    logic                  wr_done;
    logic                  retain_ack;
  } asc_host_type;

  asc_host_type r;
  asc_host_type next_r;

  logic                tmr_load;
  logic [TMR_BITS-1:0] tmr_value;
  logic                tmr_done;
  logic                turn_load;
  logic                turn_done;
  logic                capture;
  logic                accept;

  always_comb begin
    next_r           = r;
    tmr_load         = 1'b0;
    tmr_value        = '0;
    turn_load        = 1'b0;
    capture          = 1'b0;
    accept           = req_valid_i & r.ready;
    next_r.rsp_valid = 1'b0;
    next_r.wr_done   = 1'b0;

    unique case (r.state)
      ST_IDLE: begin
        // Select stays high while idle so the memory sits in standby
        next_r.cs_n = 1'b1;
        next_r.we_n = 1'b1;
        next_r.oe_n = 1'b1;
        if (retain_req_i) begin
          next_r.state = ST_RETAIN;
        end else if (accept) begin
          // Address moves only while both strobes are high
          next_r.addr  = req_addr_i;
          next_r.wdata = req_wdata_i;
          if (req_write_i) begin
            next_r.state = ST_WR_ADDR;
          end else begin
            next_r.state = ST_RD_ADDR;
          end
        end
      end

      ST_RD_ADDR: begin
        // Address was set one cycle before select falls
        next_r.cs_n  = 1'b0;
        next_r.oe_n  = 1'b0;
        next_r.state = ST_RD_ACCESS;
        tmr_load     = 1'b1;
        tmr_value    = TMR_READ;
      end

      ST_RD_ACCESS: begin
        if (tmr_done) begin
          // Sample at the last cycle of the access window
          capture          = 1'b1;
          next_r.rsp_valid = 1'b1;
          next_r.cs_n      = 1'b1;
          next_r.oe_n      = 1'b1;
          next_r.state     = ST_RD_END;
          // Memory may drive up to the high-impedance delay after this
          turn_load        = 1'b1;
        end
      end

      ST_RD_END: begin
        next_r.state = ST_IDLE;
      end

      ST_WR_ADDR: begin
        // Wait for the previous read's drivers to let go of the bus
        if (turn_done) begin
          next_r.drive = 1'b1;
          // Strobe and select fall together; outputs stay released
          next_r.cs_n  = 1'b0;
          next_r.we_n  = 1'b0;
          next_r.state = ST_WR_PULSE;
          tmr_load     = 1'b1;
          tmr_value    = TMR_WRITE;
        end
      end

      ST_WR_PULSE: begin
        if (tmr_done) begin
          // Both rise on the same edge; data held one cycle after, address at least two
          next_r.cs_n    = 1'b1;
          next_r.we_n    = 1'b1;
          next_r.wr_done = 1'b1;
          next_r.state   = ST_WR_END;
        end
      end

      ST_WR_END: begin
        // Data released only after the write has ended
        next_r.drive = 1'b0;
        next_r.state = ST_IDLE;
      end

      ST_RETAIN: begin
        next_r.cs_n       = 1'b1;
        next_r.retain_ack = 1'b1;
        if (!retain_req_i) begin
          next_r.retain_ack = 1'b0;
          next_r.state      = ST_RECOVER;
          tmr_load          = 1'b1;
          tmr_value         = TMR_RECOVER;
        end
      end

      ST_RECOVER: begin
        if (tmr_done) begin
          next_r.state = ST_IDLE;
        end
      end

      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    // Ready is registered, so it reflects the state being entered
    next_r.ready = (next_r.state == ST_IDLE) & ~retain_req_i;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= '{state:      ST_IDLE,
             addr:       '0,
             cs_n:       1'b1,
             we_n:       1'b1,
             oe_n:       1'b1,
             drive:      1'b0,
             wdata:      '0,
             ready:      1'b0,
             rsp_valid:  1'b0,
             wr_done:    1'b0,
             retain_ack: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  asc_timer #(
    .WIDTH (TMR_BITS)
  ) u_strobe_tmr (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (tmr_load),
    .value_i    (tmr_value),
    .done_o     (tmr_done)
  );

  asc_timer #(
    .WIDTH (TMR_BITS)
  ) u_turn_tmr (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (turn_load),
    .value_i    (TMR_TURN),
    .done_o     (turn_done)
  );

  // Pad stage registers from next values so it stays aligned with strobes
  asc_dq_pad #(
    .WIDTH (DATA_WIDTH)
  ) u_dq_pad (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .drive_i    (next_r.drive),
    .wdata_i    (next_r.wdata),
    .capture_i  (capture),
    .dq_i       (data_lines_i),
    .dq_o       (data_lines_o),
    .dq_oe_n_o  (data_lines_oe_n_o),
    .rdata_o    (rsp_rdata_o)
  );

  assign req_ready_o       = r.ready;
  assign rsp_valid_o       = r.rsp_valid;
  assign wr_done_o         = r.wr_done;
  assign retain_ack_o      = r.retain_ack;
  assign word_address_o    = r.addr;
  assign chip_select_n_o   = r.cs_n;
  assign write_strobe_n_o  = r.we_n;
  assign output_enable_n_o = r.oe_n;
endmodule
`default_nettype wire

// ==== rtl/asc_timer.sv ====
// Down counter used for strobe widths and bus turnaround.
// Assumes load and value come from the owner's combinational next logic.
`default_nettype none
`timescale 1ns/100ps
module asc_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] value_i,
  output logic                  done_o
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } asc_tmr_type;

  asc_tmr_type r;
  asc_tmr_type next_r;

  if (WIDTH < 2) begin : g_chk
    $error("asc_timer WIDTH too small");
  end

  always_comb begin
    next_r = r;
    if (load_i) begin
      next_r.count = value_i;
    end else if (r.count != '0) begin
      next_r.count = r.count - WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done_o = (r.count == '0);
endmodule
`default_nettype wire

// ==== testbench/asc_sram_checker.sv ====
// Pin-level checks for the static memory host controller.
// Bound to asc_sram_host and sees only its ports.
`default_nettype none
`timescale 1ns/100ps
module asc_sram_checker #(
  parameter int ADDR_WIDTH = 19,
  parameter int DATA_WIDTH = 8
) (
  input wire logic                  core_clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  req_ready_o,
  input wire logic                  wr_done_o,
  input wire logic                  retain_ack_o,
  input wire logic [ADDR_WIDTH-1:0] word_address_o,
  input wire logic                  chip_select_n_o,
  input wire logic                  write_strobe_n_o,
  input wire logic                  output_enable_n_o,
  input wire logic [DATA_WIDTH-1:0] data_lines_o,
  input wire logic                  data_lines_oe_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence wr_pulse;
    (!write_strobe_n_o && !chip_select_n_o)[*5];
  endsequence
  sequence wr_data_held;
    !data_lines_oe_n_o ##1 (!data_lines_oe_n_o && $stable(data_lines_o))[*5];
  endsequence
  sequence rd_window;
    (!output_enable_n_o && !chip_select_n_o)[*6];
  endsequence

  addr_hold_a: assert property (
    (!chip_select_n_o || !write_strobe_n_o) |-> $stable(word_address_o))
    else $error("address moved while selected");
  no_contention_a: assert property (
    (!data_lines_oe_n_o || !write_strobe_n_o) |-> output_enable_n_o)
    else $error("output enable low while host writes");
  write_pulse_a: assert property (
    $fell(write_strobe_n_o) |-> $fell(chip_select_n_o) ##0 wr_pulse
    ##1 write_strobe_n_o)
    else $error("write pulse not five cycles");
  write_data_a: assert property (
    $fell(write_strobe_n_o) |-> wr_data_held)
    else $error("write data not held over the pulse");
  write_end_a: assert property (
    $rose(write_strobe_n_o) |-> $rose(chip_select_n_o) && wr_done_o
    && $stable(word_address_o))
    else $error("write end misaligned");
  read_window_a: assert property (
    $fell(output_enable_n_o) |-> ($fell(chip_select_n_o)
    && $stable(word_address_o)) ##0 rd_window)
    else $error("read window short or address late");
  addr_gap_a: assert property (
    !$stable(word_address_o) |=> $stable(word_address_o)[*5])
    else $error("address cycle shorter than 55 ns");
  retain_sel_a: assert property (
    retain_ack_o |-> chip_select_n_o && data_lines_oe_n_o)
    else $error("selected during retention");
  retain_rec_a: assert property (
    $fell(retain_ack_o) |-> (!req_ready_o)[*6])
    else $error("recovery after retention too short");
  idle_standby_a: assert property (
    req_ready_o |-> chip_select_n_o && write_strobe_n_o && output_enable_n_o)
    else $error("idle without standby");
endmodule
`default_nettype wire

// ==== testbench/asc_sram_model.sv ====
// Behavioural model of the 512K by 8 asynchronous static memory.
// Assumes the host pins arrive straight from the controller.
`default_nettype none
`timescale 1ns/100ps
module asc_sram_model #(
  parameter int ACC_NS = 55
) (
  input  wire logic [18:0] word_address_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        write_strobe_n_i,
  input  wire logic        output_enable_n_i,
  input  wire logic [7:0]  host_data_i,
  input  wire logic        host_oe_n_i,
  output logic      [7:0]  data_lines_o
);
  logic [7:0] mem [bit [18:0]];
  logic [7:0] junk = 8'ha5;
  logic       valid = 1'b0;
  wire        wr_n;
  wire        rd;

  assign wr_n = chip_select_n_i | write_strobe_n_i;
  assign rd = !chip_select_n_i && !output_enable_n_i
              && write_strobe_n_i;
  // No pull on the bus, so released lines must not look stable
  always #5 junk = ~junk;
  always @(posedge wr_n)
    if (host_oe_n_i === 1'b0) mem[word_address_i] = host_data_i;
  // Worst case access: data only turns good at the limit. A scheduled
  // rise lets a new select start its own wait even while an older one runs
  always @(rd) begin
    valid = 1'b0;
    if (rd) valid <= #(ACC_NS) 1'b1;
  end
  // No output hold assumed: old data turns to junk at once
  always @(valid or rd or junk or word_address_i or host_oe_n_i
           or host_data_i) begin
    if (valid && rd && mem.exists(word_address_i))
      data_lines_o = mem[word_address_i];
    else
      data_lines_o = junk;
    if (host_oe_n_i === 1'b0)
      data_lines_o = host_data_i;
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the static memory host controller.
// Assumes asc_sram_model on the pins and the bound pin checker.
`default_nettype none
`timescale 1ns/100ps
module testbench;
  import asc_pkg::*;
  logic                 core_clk_i = 1'b0;
  logic                 sys_rst_i;
  logic                 req_valid_i;
  logic                 req_write_i;
  logic [ADDR_BITS-1:0] req_addr_i;
  logic [DATA_BITS-1:0] req_wdata_i;
  logic                 retain_req_i;
  logic                 req_ready_o;
  logic                 rsp_valid_o;
  logic [DATA_BITS-1:0] rsp_rdata_o;
  logic                 wr_done_o;
  logic                 retain_ack_o;
  logic [ADDR_BITS-1:0] word_address_o;
  logic                 chip_select_n_o;
  logic                 write_strobe_n_o;
  logic                 output_enable_n_o;
  logic [DATA_BITS-1:0] data_lines_o;
  logic                 data_lines_oe_n_o;
  logic [DATA_BITS-1:0] data_lines_i;
  int                   fail_count = 0;
  int                   cmp_count = 0;
  int                   cyc = 0;

  asc_sram_host u_asc_sram_host (
    .core_clk_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_addr_i,
    .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .wr_done_o,
    .retain_req_i, .retain_ack_o, .word_address_o, .chip_select_n_o,
    .write_strobe_n_o, .output_enable_n_o, .data_lines_o,
    .data_lines_oe_n_o, .data_lines_i
  );
  asc_sram_model u_asc_sram_model (
    .word_address_i(word_address_o), .chip_select_n_i(chip_select_n_o),
    .write_strobe_n_i(write_strobe_n_o),
    .output_enable_n_i(output_enable_n_o), .host_data_i(data_lines_o),
    .host_oe_n_i(data_lines_oe_n_o), .data_lines_o(data_lines_i)
  );

  always #5 core_clk_i = ~core_clk_i;
  // About a hundred cycles are needed; the 3000-cycle ceiling leaves wide margin
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One request; data d is written, or expected back on a read
  task automatic xfer(input logic w, input logic [18:0] a,
                      input logic [7:0] d);
    int n;
    n = 1;
    @(negedge core_clk_i);
    req_valid_i = 1'b1;
    req_write_i = w;
    req_addr_i = a;
    req_wdata_i = d;
    do @(posedge core_clk_i); while (req_ready_o !== 1'b1);
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    while (n < 20 && (w ? wr_done_o : rsp_valid_o) !== 1'b1) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(32'(n), w ? 32'h7 : 32'h8);
    if (!w) chk(32'(rsp_rdata_o), 32'(d));
  endtask

  task automatic check_reset();
    chk(32'(chip_select_n_o), 32'h1);
    chk(32'({write_strobe_n_o, output_enable_n_o}), 32'h3);
    chk(32'({data_lines_oe_n_o, req_ready_o}), 32'h2);
  endtask

  task automatic boundary_rw();
    logic [18:0] a [3] = '{19'h00000, 19'h7ffff, 19'h2a5a5};
    logic [7:0]  d [3] = '{8'h3c, 8'hc3, 8'h00};
    foreach (a[i]) xfer(1'h1, a[i], d[i]);
    foreach (a[i]) xfer(1'h0, a[i], d[i]);
  endtask

  task automatic overwrite();
    xfer(1'h1, 19'h12345, 8'h11);
    xfer(1'h1, 19'h12345, 8'hee);
    xfer(1'h0, 19'h12345, 8'hee);
  endtask

  task automatic retention();
    int n;
    n = 0;
    @(negedge core_clk_i);
    retain_req_i = 1'b1;
    // Acknowledge shows one cycle after the retention state is entered
    repeat (2) @(negedge core_clk_i);
    chk(32'({retain_ack_o, chip_select_n_o, req_ready_o}), 32'h6);
    retain_req_i = 1'b0;
    @(negedge core_clk_i);
    chk(32'(retain_ack_o), 32'h0);
    while (req_ready_o !== 1'b1 && n < 40) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(32'(n), 32'h6);
    xfer(1'h0, 19'h7ffff, 8'hc3);
  endtask

  initial begin
    sys_rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = '0;
    req_wdata_i = '0;
    retain_req_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check_reset();
    sys_rst_i = 1'b0;
    boundary_rw();
    overwrite();
    retention();
    tally_and_finish();
  end
endmodule

bind asc_sram_host asc_sram_checker #(
  .ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)
) u_asc_sram_checker (
  .core_clk_i, .sys_rst_i, .req_ready_o, .wr_done_o, .retain_ack_o,
  .word_address_o, .chip_select_n_o, .write_strobe_n_o,
  .output_enable_n_o, .data_lines_o, .data_lines_oe_n_o
);
`default_nettype wire
